/* File: dv/flash_cmd_properties.sv */
`timescale 1ns/1ps
`include "flash_cmd_regs.svh"

module flash_cmd_properties
   import flash_cmd_pkg::*;
#(
   parameter int PROG_TIME_US = 1,
   parameter int PE_TIME_US   = 1,
   parameter int BE_TIME_US   = 2,
   parameter int SE_TIME_US   = 3
)
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // Link wires and host readiness
   input  wire logic        csN,
   input  wire logic        sck,
   input  wire logic        cmdReady_r,
   // Device operation outputs
   input  wire logic        opStart_r,
   input  wire opKind_t     opKind_r,
   input  wire logic [9:0]  opFirstPage_r,
   input  wire logic [7:0]  opPageCount_r,
   input  wire logic        busy_r,
   input  wire logic        opDone_r
);

   // ****************************************************************
   // Helper logic
   // ****************************************************************
   logic [15:0] busyCnt_r;

   // Busy length of the kind that was launched, in clock cycles.
   function automatic int opLen(opKind_t k);
      case (k)
         OP_PROGRAM:     return PROG_TIME_US * `CLK_MHZ;
         OP_PAGE_ERASE:  return PE_TIME_US * `CLK_MHZ;
         OP_BLOCK_ERASE: return BE_TIME_US * `CLK_MHZ;
         default:        return SE_TIME_US * `CLK_MHZ;
      endcase
   endfunction

   // Counts busy cycles; a fixed repetition could not hold hundreds of cycles.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         busyCnt_r <= 16'h0000;
      else if (opStart_r)
         busyCnt_r <= 16'h0001;
      else if (busy_r)
         busyCnt_r <= busyCnt_r + 16'h0001;
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   a_start_raises_busy: assert property (opStart_r |-> busy_r && !$past(busy_r))
      else $error("launch without a fresh busy");
   a_start_after_frame: assert property (opStart_r |-> csN && !sck)
      else $error("launch while the frame is open");
   a_start_single: assert property (opStart_r |=> !opStart_r)
      else $error("launch pulse longer than one cycle");
   a_busy_exact_length: assert property (opDone_r |-> busyCnt_r == opLen(opKind_r))
      else $error("busy length differs from the operation time");
   a_done_in_time: assert property ($rose(busy_r) |-> ##[1:1000] opDone_r)
      else $error("operation never completed");
   a_done_ends_busy: assert property (opDone_r |-> !busy_r && $past(busy_r))
      else $error("done pulse not at busy fall");
   a_page_single: assert property (opStart_r && (opKind_r == OP_PROGRAM ||
      opKind_r == OP_PAGE_ERASE) |-> opPageCount_r == 8'h01)
      else $error("single page operation spans several pages");
   a_block_aligned: assert property (opStart_r && opKind_r == OP_BLOCK_ERASE |->
      opPageCount_r == 8'h08 && opFirstPage_r[2:0] == 3'h0)
      else $error("block erase not eight aligned pages");
   a_sector_shape: assert property (opStart_r && opKind_r == OP_SECTOR_ERASE |->
      (opPageCount_r == 8'h80 && opFirstPage_r[6:0] == 7'h00) ||
      (opPageCount_r == 8'h08 && opFirstPage_r == 10'h000) ||
      (opPageCount_r == 8'h78 && opFirstPage_r == 10'h008))
      else $error("sector erase extent not a sector");
   a_link_idle_low: assert property (csN |-> !sck)
      else $error("serial clock moves outside a frame");
   a_ready_frame: assert property (!csN |-> !cmdReady_r)
      else $error("host ready during an open frame");

   // Main scenarios reached.
   c_block: cover property (opStart_r && opKind_r == OP_BLOCK_ERASE);
   c_sub0b: cover property (opStart_r && opPageCount_r == 8'h78);
   c_done: cover property (opDone_r);

endmodule

/* File: dv/test_serial_flash_program_erase_cmds.sv */
`timescale 1ns/1ps

`define CHK(nm, e, g) \
   n_compared++; \
   if ((g) !== (e)) \
   begin \
      n_mismatch++; \
      $display("unexpected %s expected %0h seen %0h", nm, e, g); \
   end

module test_serial_flash_program_erase_cmds
   import flash_cmd_pkg::*;
;
   localparam int PT = 1;
   localparam int ET = 1;
   localparam int BT = 2;
   localparam int ST = 3;

   // ****************************************************************
   // Signals and instances
   // ****************************************************************
   logic        sys_clk, rst, ce, pageSize256, cmdValid, cmdReady_r;
   cmdKind_t    cmdKind;
   logic [9:0]  cmdPage;
   logic        opStart_r, busy_r, opDone_r, rawStart, rawBusy;
   opKind_t     opKind_r;
   logic [9:0]  opFirstPage_r, rawFirst;
   logic [7:0]  opPageCount_r;
   int          n_mismatch = 0, n_compared = 0, starts = 0, rawStarts = 0, busyLen = 0;

   flash_link_if link();
   flash_link_if rawLink();

   flash_cmd_host flash_cmd_host_i (.sys_clk(sys_clk), .rst(rst), .ce(ce),
      .pageSize256(pageSize256), .cmdValid(cmdValid), .cmdKind(cmdKind), .cmdPage(cmdPage),
      .cmdByteIndex(9'h0A5), .cmdReady_r(cmdReady_r), .link(link));
   flash_cmd_device #(.PROG_TIME_US(PT), .PE_TIME_US(ET), .BE_TIME_US(BT), .SE_TIME_US(ST))
      flash_cmd_device_i (.sys_clk(sys_clk), .rst(rst), .ce(ce), .pageSize256(pageSize256),
      .link(link), .opStart_r(opStart_r), .opKind_r(opKind_r), .opFirstPage_r(opFirstPage_r),
      .opPageCount_r(opPageCount_r), .busy_r(busy_r), .opDone_r(opDone_r));
   // Second device on a bench-driven link, for frames the host never sends.
   flash_cmd_device #(.PROG_TIME_US(PT), .PE_TIME_US(ET), .BE_TIME_US(BT), .SE_TIME_US(ST))
      flash_cmd_device_i2 (.sys_clk(sys_clk), .rst(rst), .ce(ce), .pageSize256(pageSize256),
      .link(rawLink), .opStart_r(rawStart), .opKind_r(), .opFirstPage_r(rawFirst),
      .opPageCount_r(), .busy_r(rawBusy), .opDone_r());
   flash_cmd_properties #(.PROG_TIME_US(PT), .PE_TIME_US(ET), .BE_TIME_US(BT), .SE_TIME_US(ST))
      flash_cmd_properties_i (.sys_clk(sys_clk), .rst(rst), .csN(link.csN), .sck(link.sck),
      .cmdReady_r(cmdReady_r), .opStart_r(opStart_r), .opKind_r(opKind_r),
      .opFirstPage_r(opFirstPage_r), .opPageCount_r(opPageCount_r), .busy_r(busy_r),
      .opDone_r(opDone_r));

   // ****************************************************************
   // Clock, monitor and watchdog
   // ****************************************************************
   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // Sampled on the rising edge so the falling-edge tasks never race it.
   always @(posedge sys_clk)
   begin
      if (opStart_r === 1'b1)
         busyLen = 1;
      else if (busy_r === 1'b1)
         busyLen++;
      if (opStart_r === 1'b1)
         starts++;
      if (rawStart === 1'b1)
         rawStarts++;
   end

   // The run needs about 10000 cycles; this allows 25000.
   initial
   begin
      #100000;
      n_mismatch++;
      finish_test();
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic doCmd(cmdKind_t k, logic [9:0] pg, bit exp, opKind_t eK, logic [9:0] eF,
                        logic [7:0] eC);
      int s0 = starts;
      int n  = 0;
      while (cmdReady_r !== 1'b1 && n < 500)
      begin
         @(negedge sys_clk);
         n++;
      end
      cmdKind  = k;
      cmdPage  = pg;
      cmdValid = 1'b1;
      @(negedge sys_clk);
      cmdValid = 1'b0;
      n = 0;
      while (cmdReady_r !== 1'b1 && n < 500)
      begin
         @(negedge sys_clk);
         n++;
      end
      // A host that never re-arms counts as a mismatch here, not as a silent hang.
      `CHK("ready", 1'b1, cmdReady_r)
      // Slack for the device to see the frame end.
      repeat (8) @(negedge sys_clk);
      `CHK("starts", s0 + int'(exp), starts)
      if (exp)
      begin
         `CHK("kind", eK, opKind_r)
         `CHK("first", eF, opFirstPage_r)
         `CHK("count", eC, opPageCount_r)
      end
   endtask

   task automatic waitBusy(int eN);
      int n = 0;
      while (busy_r !== 1'b0 && n < 2000)
      begin
         @(negedge sys_clk);
         n++;
      end
      `CHK("done", 1'b1, opDone_r)
      `CHK("busy length", eN, busyLen)
   endtask

   // Released data line shows the inverse of its last bit, not a held value.
   task automatic rawCmd(logic [31:0] v, int nb, bit exp, logic [9:0] eF);
      int s0 = rawStarts;
      int n  = 0;
      for (int i = 31; i > 31 - nb; i--)
      begin
         rawLink.csN  = 1'b0;
         rawLink.mosi = v[i];
         repeat (2) @(negedge sys_clk);
         rawLink.sck = 1'b1;
         repeat (2) @(negedge sys_clk);
         rawLink.sck = 1'b0;
      end
      rawLink.csN  = 1'b1;
      rawLink.mosi = ~rawLink.mosi;
      repeat (8) @(negedge sys_clk);
      `CHK("raw starts", s0 + int'(exp), rawStarts)
      // The macro holds several statements, so the guard needs its own block.
      if (exp)
      begin
         `CHK("raw first", eF, rawFirst)
      end
      while (rawBusy !== 1'b0 && n < 2000)
      begin
         @(negedge sys_clk);
         n++;
      end
      `CHK("raw idle", 1'b0, rawBusy)
   endtask

   task automatic finish_test();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ****************************************************************
   // Tests, in both page layouts
   // ****************************************************************
   initial
   begin
      rst = 1'b1;
      ce = 1'b0;
      pageSize256 = 1'b0;
      cmdValid = 1'b0;
      cmdKind = CMD_PROGRAM;
      cmdPage = 10'h000;
      rawLink.csN = 1'b1;
      rawLink.sck = 1'b0;
      rawLink.mosi = 1'b0;
      repeat (5) @(negedge sys_clk);
      rst = 1'b0;
      // With the enable low the host must not offer itself after reset.
      repeat (3) @(negedge sys_clk);
      `CHK("frozen ready", 1'b0, cmdReady_r)
      ce = 1'b1;
      for (int m = 0; m < 2; m++)
      begin
         pageSize256 = m[0];
         doCmd(CMD_PAGE_ERASE, 10'h3FF, 1, OP_PAGE_ERASE, 10'h3FF, 8'h01);
         waitBusy(ET * 250);
         doCmd(CMD_PROGRAM, 10'h3FF, 1, OP_PROGRAM, 10'h3FF, 8'h01);
         waitBusy(PT * 250);
         doCmd(CMD_BLOCK_ERASE, 10'h2AD, 1, OP_BLOCK_ERASE, 10'h2A8, 8'h08);
         waitBusy(BT * 250);
         doCmd(CMD_SECTOR_ERASE, 10'h005, 1, OP_SECTOR_ERASE, 10'h000, 8'h08);
         waitBusy(ST * 250);
         doCmd(CMD_SECTOR_ERASE, 10'h07F, 1, OP_SECTOR_ERASE, 10'h008, 8'h78);
         doCmd(CMD_PAGE_ERASE, 10'h001, 0, OP_NONE, 10'h000, 8'h00);
         waitBusy(ST * 250);
         doCmd(CMD_SECTOR_ERASE, 10'h1C3, 1, OP_SECTOR_ERASE, 10'h180, 8'h80);
         waitBusy(ST * 250);
         doCmd(CMD_BUF_WRITE, 10'h000, 0, OP_NONE, 10'h000, 8'h00);
         rawCmd(32'h8100_2B60, 31, 0, 10'h000);
         rawCmd(m ? {8'h81, 6'h3F, 10'h2B6, 8'hFF} : {8'h81, 5'h1F, 10'h2B6, 9'h1FF},
                32, 1, 10'h2B6);
      end
      finish_test();
   end

endmodule

/* File: rtl/flash_cmd_device.sv */
`timescale 1ns/1ps
`include "flash_cmd_regs.svh"

// What this block does
// - Opcode 88H then three address bytes
// - 264 mode: 5 ignored, page, 9 ignored
// - 256 mode: 6 ignored, BINARY_PAGE_BITS page, 8 ignored
// - Chip-select rise starts program, busy until done
// - Host programs only previously erased pages
// - Page erase 81H, 264 layout as program
// - Page erase 81H, 256 layout as program
// - Page erase sets page to ones, busy
// - Block erase 50H, 264: block in PA9-PA3
// - Block erase 50H, 256: block in A17-A11
// - Block is eight pages, upper seven bits
// - Block erase erases eight pages, busy
// - Sector 0a/0b, 264: seven upper page bits
// - Sectors 1-7, 264: top three page bits
// - Sector 0a/0b, 256: bits A17-A11
// - Sectors 1-7, 256: bits A17-A15
// - Sector decode: 0a, 0b, else top bits
// - Sector erase erases one sector, busy
// - Buffer filled earlier by opcode 84H
module flash_cmd_device
   import flash_cmd_pkg::*;
#(
   parameter int PROG_TIME_US = `PROG_TIME_US_DFLT,
   parameter int PE_TIME_US   = `PE_TIME_US_DFLT,
   parameter int BE_TIME_US   = `BE_TIME_US_DFLT,
   parameter int SE_TIME_US   = `SE_TIME_US_DFLT
)
(
   // Clock, reset and enable
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire logic              ce,
   // Configuration
   input  wire logic              pageSize256,
   // Serial link
   flash_link_if.dev_mp           link,
   // Operation toward the array
   output      logic              opStart_r,
   output      opKind_t           opKind_r,
   output      logic [9:0]        opFirstPage_r,
   output      logic [7:0]        opPageCount_r,
   output      logic              busy_r,
   output      logic              opDone_r
);

   // ****************************************************************
   // Timing constants
   // ****************************************************************
   localparam logic [31:0] PROG_CYC = 32'(PROG_TIME_US * `CLK_MHZ);
   localparam logic [31:0] PE_CYC   = 32'(PE_TIME_US * `CLK_MHZ);
   localparam logic [31:0] BE_CYC   = 32'(BE_TIME_US * `CLK_MHZ);
   localparam logic [31:0] SE_CYC   = 32'(SE_TIME_US * `CLK_MHZ);

   // ****************************************************************
   // Link sampling
   // ****************************************************************
   logic              sckPrev_r;
   logic              csPrev_r;
   logic [31:0]       shift_r;
   logic [5:0]        bitCnt_r;
   logic              sckRise;
   logic              csRise;

   // Link pins are synchronous to sys_clk, so one stage of history finds edges.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         sckPrev_r <= 1'b0;
         csPrev_r  <= 1'b1;
      end
      else if (ce)
      begin
         sckPrev_r <= link.sck;
         csPrev_r  <= link.csN;
      end
   end

   assign sckRise = link.sck & ~sckPrev_r & ~link.csN;
   assign csRise  = link.csN & ~csPrev_r;

   // Bits beyond the fourth byte are dropped; a buffer write's data is not ours.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         shift_r  <= '0;
         bitCnt_r <= '0;
      end
      else if (ce)
      begin
         if (link.csN)
         begin
            bitCnt_r <= '0;
         end
         else if (sckRise && bitCnt_r != `CMD_BITS)
         begin
            shift_r  <= {shift_r[30:0], link.mosi};
            bitCnt_r <= bitCnt_r + 6'h01;
         end
      end
   end

   // ****************************************************************
   // Command decode
   // ****************************************************************
   logic [7:0]        opcode;
   logic [23:0]       addr;
   logic [9:0]        page;
   logic [6:0]        blockIdx;
   logic [2:0]        sectorIdx;
   opKind_t           kind;
   logic [9:0]        firstPage;
   logic [7:0]        pageCount;
   logic [31:0]       opCycles;

   assign opcode = shift_r[31:24];
   assign addr   = shift_r[23:0];

   // Only the page field is taken; bits outside it never reach the decode.
   assign page = pageSize256 ? addr[`PAGE256_LSB +: `PAGE_W]
                             : addr[`PAGE264_LSB +: `PAGE_W];
   assign blockIdx  = page[9:`BLOCK_LSB];
   assign sectorIdx = page[9:`SECTOR_LSB];

   // Opcode and address give the operation, its extent and its time.
   always_comb
   begin
      kind      = OP_NONE;
      firstPage = page;
      pageCount = `PAGES_ONE;
      opCycles  = PROG_CYC;
      if (opcode == `OPC_PROG_NO_ERASE)
      begin
         kind = OP_PROGRAM;
      end
      else if (opcode == `OPC_PAGE_ERASE)
      begin
         kind     = OP_PAGE_ERASE;
         opCycles = PE_CYC;
      end
      else if (opcode == `OPC_BLOCK_ERASE)
      begin
         kind      = OP_BLOCK_ERASE;
         firstPage = {blockIdx, 3'b000};
         pageCount = `PAGES_BLOCK;
         opCycles  = BE_CYC;
      end
      else if (opcode == `OPC_SECTOR_ERASE)
      begin
         kind     = OP_SECTOR_ERASE;
         opCycles = SE_CYC;
         if (sectorIdx != 3'b000)
         begin
            firstPage = {sectorIdx, 7'b000_0000};
            pageCount = `PAGES_SECTOR;
         end
         else if (blockIdx == 7'b000_0000)
         begin
            firstPage = '0;
            pageCount = `PAGES_BLOCK;
         end
         else
         begin
            firstPage = `FIRST_SUB0B;
            pageCount = `PAGES_SUB0B;
         end
      end
   end

   // ****************************************************************
   // Self-timed sequencer
   // ****************************************************************
   devState_t         state_r;
   logic [31:0]       timer_r;
   logic              launch;

   // A frame counts only when all 32 bits arrived; new frames while busy are ignored.
   assign launch = csRise && state_r == D_IDLE && bitCnt_r == `CMD_BITS
                   && kind != OP_NONE;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state_r <= D_IDLE;
         timer_r <= '0;
         busy_r  <= 1'b0;
      end
      else if (ce)
      begin
         case (state_r)
            D_IDLE:
            begin
               if (launch)
               begin
                  state_r <= D_BUSY;
                  busy_r  <= 1'b1;
                  timer_r <= opCycles - 32'h0000_0001;
               end
            end
            D_BUSY:
            begin
               if (timer_r == '0)
               begin
                  state_r <= D_IDLE;
                  busy_r  <= 1'b0;
               end
               else
               begin
                  timer_r <= timer_r - 32'h0000_0001;
               end
            end
            default:
            begin
               state_r <= D_IDLE;
            end
         endcase
      end
   end

   // Descriptor of the running operation is held for the whole busy time.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         opStart_r     <= 1'b0;
         opDone_r      <= 1'b0;
         opKind_r      <= OP_NONE;
         opFirstPage_r <= '0;
         opPageCount_r <= '0;
      end
      else if (ce)
      begin
         opStart_r <= launch;
         opDone_r  <= state_r == D_BUSY && timer_r == '0;
         if (launch)
         begin
            opKind_r      <= kind;
            opFirstPage_r <= firstPage;
            opPageCount_r <= pageCount;
         end
      end
   end

endmodule

/* File: rtl/flash_cmd_host.sv */
`timescale 1ns/1ps
`include "flash_cmd_regs.svh"

module flash_cmd_host
   import flash_cmd_pkg::*;
#(
   parameter logic [7:0] SCK_HALF = `HOST_SCK_HALF,
   parameter logic [7:0] CS_GAP   = `HOST_CS_GAP
)
(
   // Clock, reset and enable
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire logic              ce,
   // Configuration
   input  wire logic              pageSize256,
   // Command request
   input  wire logic              cmdValid,
   input  cmdKind_t               cmdKind,
   input  wire logic [9:0]        cmdPage,
   input  wire logic [8:0]        cmdByteIndex,
   output      logic              cmdReady_r,
   // Serial link
   flash_link_if.host_mp          link
);

   // ****************************************************************
   // Frame build
   // ****************************************************************
   logic [7:0]        opcode;
   logic [9:0]        pageField;
   logic [23:0]       addr;

   // Ignored positions are sent as zero; the caller must only program erased pages.
   always_comb
   begin
      opcode    = `OPC_PROG_NO_ERASE;
      pageField = cmdPage;
      addr      = '0;
      case (cmdKind)
         CMD_BUF_WRITE:    opcode = `OPC_BUF_WRITE;
         CMD_PAGE_ERASE:   opcode = `OPC_PAGE_ERASE;
         CMD_BLOCK_ERASE:
         begin
            opcode    = `OPC_BLOCK_ERASE;
            pageField = {cmdPage[9:`BLOCK_LSB], 3'b000};
         end
         CMD_SECTOR_ERASE:
         begin
            opcode = `OPC_SECTOR_ERASE;
            if (cmdPage[9:`SECTOR_LSB] != 3'b000)
            begin
               pageField = {cmdPage[9:`SECTOR_LSB], 7'b000_0000};
            end
            else
            begin
               pageField = {cmdPage[9:`BLOCK_LSB], 3'b000};
            end
         end
         default:          opcode = `OPC_PROG_NO_ERASE;
      endcase
      if (cmdKind == CMD_BUF_WRITE)
      begin
         if (pageSize256)
         begin
            addr[`BYTE256_W-1:0] = cmdByteIndex[`BYTE256_W-1:0];
         end
         else
         begin
            addr[`BYTE264_W-1:0] = cmdByteIndex;
         end
      end
      else if (pageSize256)
      begin
         addr[`PAGE256_LSB +: `PAGE_W] = pageField;
      end
      else
      begin
         addr[`PAGE264_LSB +: `PAGE_W] = pageField;
      end
   end

   // ****************************************************************
   // Serial engine
   // ****************************************************************
   hostState_t        state_r;
   logic [31:0]       shift_r;
   logic [5:0]        bitCnt_r;
   logic [7:0]        div_r;
   logic              csN_r;
   logic              sck_r;
   logic              mosi_r;

   assign link.csN  = csN_r;
   assign link.sck  = sck_r;
   assign link.mosi = mosi_r;

   // Mode 0: data changes while clock is low, the device samples on the rise.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state_r    <= H_IDLE;
         shift_r    <= '0;
         bitCnt_r   <= '0;
         div_r      <= '0;
         csN_r      <= 1'b1;
         sck_r      <= 1'b0;
         mosi_r     <= 1'b0;
         cmdReady_r <= 1'b0;
      end
      else if (ce)
      begin
         case (state_r)
            H_IDLE:
            begin
               cmdReady_r <= 1'b1;
               if (cmdValid && cmdReady_r)
               begin
                  shift_r    <= {opcode, addr};
                  mosi_r     <= opcode[7];
                  csN_r      <= 1'b0;
                  cmdReady_r <= 1'b0;
                  div_r      <= '0;
                  bitCnt_r   <= '0;
                  state_r    <= H_SHIFT;
               end
            end
            H_SHIFT:
            begin
               if (div_r == SCK_HALF - 8'h01)
               begin
                  div_r <= '0;
                  if (!sck_r)
                  begin
                     sck_r    <= 1'b1;
                     bitCnt_r <= bitCnt_r + 6'h01;
                  end
                  else
                  begin
                     sck_r <= 1'b0;
                     if (bitCnt_r == `CMD_BITS)
                     begin
                        // Raising select only after the full frame launches the operation.
                        csN_r   <= 1'b1;
                        mosi_r  <= 1'b0;
                        state_r <= H_GAP;
                     end
                     else
                     begin
                        shift_r <= {shift_r[30:0], 1'b0};
                        mosi_r  <= shift_r[30];
                     end
                  end
               end
               else
               begin
                  div_r <= div_r + 8'h01;
               end
            end
            H_GAP:
            begin
               if (div_r == CS_GAP - 8'h01)
               begin
                  div_r   <= '0;
                  state_r <= H_IDLE;
               end
               else
               begin
                  div_r <= div_r + 8'h01;
               end
            end
            default:
            begin
               state_r <= H_IDLE;
            end
         endcase
      end
   end

endmodule

/* File: rtl/flash_cmd_pkg.sv */
package flash_cmd_pkg;

   // Operation that the device sequencer runs.
   typedef enum logic [2:0] {OP_NONE, OP_PROGRAM, OP_PAGE_ERASE, OP_BLOCK_ERASE,
                             OP_SECTOR_ERASE} opKind_t;

   // Command that the host issues.
   typedef enum logic [2:0] {CMD_BUF_WRITE, CMD_PROGRAM, CMD_PAGE_ERASE,
                             CMD_BLOCK_ERASE, CMD_SECTOR_ERASE} cmdKind_t;

   typedef enum logic [0:0] {D_IDLE, D_BUSY} devState_t;

   typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_GAP} hostState_t;

endpackage

/* File: rtl/flash_cmd_regs.svh */
`ifndef FLASH_CMD_REGS_SVH
`define FLASH_CMD_REGS_SVH

// ****************************************************************
// Command opcodes
// ****************************************************************
`define OPC_BUF_WRITE      8'h84
`define OPC_PROG_NO_ERASE  8'h88
`define OPC_PAGE_ERASE     8'h81
`define OPC_BLOCK_ERASE    8'h50
`define OPC_SECTOR_ERASE   8'h7C

// ****************************************************************
// Frame and address layout
// ****************************************************************
`define CMD_BITS           6'h20
`define PAGE_W             10
`define PAGE264_LSB        9
`define PAGE256_LSB        8
`define BLOCK_LSB          3
`define SECTOR_LSB         7
`define BYTE264_W          9
`define BYTE256_W          8

// ****************************************************************
// Operation extents in pages
// ****************************************************************
`define PAGES_ONE          8'h01
`define PAGES_BLOCK        8'h08
`define PAGES_SUB0B        8'h78
`define PAGES_SECTOR       8'h80
`define FIRST_SUB0B        10'h008

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_MHZ            250
`define PROG_TIME_US_DFLT  2000
`define PE_TIME_US_DFLT    2000
`define BE_TIME_US_DFLT    4000
`define SE_TIME_US_DFLT    50000
`define HOST_SCK_HALF      8'h02
`define HOST_CS_GAP        8'h04

`endif

/* File: rtl/flash_link_if.sv */
`timescale 1ns/1ps
interface flash_link_if;
   logic csN;
   logic sck;
   logic mosi;

   modport host_mp (output csN, output sck, output mosi);
   modport dev_mp  (input csN, input sck, input mosi);
endinterface
